/* File: common/tcss_params.svh */
// constants of the timer channel synchronisation select block
`ifndef TCSS_PARAMS_SVH
`define TCSS_PARAMS_SVH

`define TCSS_ADDR_W 8
`define TCSS_DATA_W 32
`define TCSS_CNT_W 16
`define TCSS_NCH 5
`define TCSS_IDX_W 3

// word and bank index fields of a byte address, byte lane width
`define TCSS_WORD_LSB 2
`define TCSS_BANK_MSB 4
`define TCSS_BYTE_W 8

// register byte offsets
`define TCSS_OFF_SYNC 8'h00
`define TCSS_OFF_START 8'h04
`define TCSS_OFF_CNT0 8'h10
`define TCSS_OFF_CTL0 8'h30

// synchronisation select layout
`define TCSS_SYNC_W 8
`define TCSS_SYNC_RST 8'h00
`define TCSS_SYNC_MASK 8'hC7
`define TCSS_BIT_CH0 3'h0
`define TCSS_BIT_CH1 3'h1
`define TCSS_BIT_CH2 3'h2
`define TCSS_BIT_CH3 3'h6
`define TCSS_BIT_CH4 3'h7

// counter clear-source codes
`define TCSS_CCLR_W 3
`define TCSS_CCLR_NONE 3'h0
`define TCSS_CCLR_OWN 3'h1
`define TCSS_CCLR_SYNC 3'h3

`define TCSS_START_RST 5'h00
`define TCSS_CNT_RST 16'h0000
`define TCSS_CNT_ONE 16'h0001

`endif

/* File: common/tcss_pkg.sv */
// types of the timer channel synchronisation select block
`include "tcss_params.svh"

package tcss_pkg;

    typedef logic [`TCSS_CNT_W-1:0] tcss_cnt_t;

    // per-channel counter control; preset and clear act on each clock, run is a held level
    typedef struct packed {
        logic run;
        logic preset;
        logic clear;
        tcss_cnt_t preset_val;
    } tcss_chan_ctl_s;

    typedef logic [`TCSS_NCH-1:0][`TCSS_CNT_W-1:0] tcss_cnt_arr_t;
    typedef logic [`TCSS_NCH-1:0][`TCSS_CCLR_W-1:0] tcss_cclr_arr_t;

endpackage

/* File: core/tcss_chan.sv */
// one channel up-counter with preset and clear
`timescale 1ns/1ps
`include "tcss_params.svh"

module tcss_chan
(
    input wire logic clk,
    input wire logic rst_n,
    input wire tcss_pkg::tcss_chan_ctl_s ctl,
    output tcss_pkg::tcss_cnt_t count
);
    import tcss_pkg::*;

    tcss_cnt_t count_r;

    // preset beats clear, clear beats counting
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            count_r <= `TCSS_CNT_RST;
        else if (ctl.preset)
            count_r <= ctl.preset_val;
        else if (ctl.clear)
            count_r <= `TCSS_CNT_RST;
        else if (ctl.run)
            count_r <= count_r + `TCSS_CNT_ONE;
    end

    assign count = count_r;

endmodule

/* File: core/tcss_top.sv */
// timer channel synchronisation select with counters and bus slave
`timescale 1ns/1ps
`include "tcss_params.svh"

// What this block does
// - eight-bit read/write sync select register covers channels 0 to 4
// - a channel runs synchronised exactly when its select bit is 1
// - channel 4 select at bit 7, channel 3 at bit 6, reset 0
// - channels 2, 1, 0 select at bits 2, 1, 0, reset 0
// - bits 5 to 3 read 0; software writes only 0 there
// - writing one synchronised counter presets all synchronised counters
// - clearing one synchronised counter clears those set to sync-clear
// - unselected channel's preset or clear is isolated from others
module tcss_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`TCSS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`TCSS_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`TCSS_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [`TCSS_NCH-1:0] clear_event,
    output tcss_pkg::tcss_cnt_arr_t channel_up_counter,
    output logic [`TCSS_SYNC_W-1:0] channel_sync_select
);
    import tcss_pkg::*;

    // ********************************
    // decode helpers
    // ********************************

    // select bit position of a channel
    function automatic logic [2:0] sync_bit_of(input int ch);
        case (ch)
            0: sync_bit_of = `TCSS_BIT_CH0;
            1: sync_bit_of = `TCSS_BIT_CH1;
            2: sync_bit_of = `TCSS_BIT_CH2;
            3: sync_bit_of = `TCSS_BIT_CH3;
            4: sync_bit_of = `TCSS_BIT_CH4;
            default: sync_bit_of = `TCSS_BIT_CH0;
        endcase
    endfunction

    // hit in a bank of per-channel words, index in low bits
    function automatic logic [`TCSS_IDX_W:0] bank_hit(
        input logic [`TCSS_ADDR_W-1:0] addr,
        input logic [`TCSS_ADDR_W-1:0] base
    );
        logic [`TCSS_ADDR_W-1:0] rel;
        rel = addr - base;
        bank_hit = {1'h0, rel[`TCSS_BANK_MSB:`TCSS_WORD_LSB]};
        if (addr >= base && rel[`TCSS_ADDR_W-1:`TCSS_BANK_MSB+1] == '0 &&
            rel[`TCSS_BANK_MSB:`TCSS_WORD_LSB] < 3'(`TCSS_NCH))
            bank_hit[`TCSS_IDX_W] = 1'h1;
    endfunction

    // merge written byte lanes over an old value
    function automatic tcss_cnt_t lane_merge(
        input tcss_cnt_t old_v,
        input logic [`TCSS_DATA_W-1:0] wd,
        input logic [3:0] be
    );
        lane_merge = old_v;
        if (be[0])
            lane_merge[`TCSS_BYTE_W-1:0] = wd[`TCSS_BYTE_W-1:0];
        if (be[1])
            lane_merge[`TCSS_CNT_W-1:`TCSS_BYTE_W] =
                wd[`TCSS_CNT_W-1:`TCSS_BYTE_W];
    endfunction

    // ********************************
    // bus decode
    // ********************************

    logic [`TCSS_ADDR_W-1:0] word_addr;
    logic [`TCSS_IDX_W:0] cnt_dec;
    logic [`TCSS_IDX_W:0] ctl_dec;
    logic hit_sync;
    logic hit_start;
    logic wr_cnt;
    logic [`TCSS_IDX_W-1:0] wr_idx;
    logic rd_ack_r;

    assign word_addr = {avs_address[`TCSS_ADDR_W-1:`TCSS_WORD_LSB], 2'h0};
    assign cnt_dec = bank_hit(word_addr, `TCSS_OFF_CNT0);
    assign ctl_dec = bank_hit(word_addr, `TCSS_OFF_CTL0);
    assign hit_sync = word_addr == `TCSS_OFF_SYNC;
    assign hit_start = word_addr == `TCSS_OFF_START;
    assign wr_cnt = avs_write && cnt_dec[`TCSS_IDX_W];
    assign wr_idx = cnt_dec[`TCSS_IDX_W-1:0];

    // writes complete at once, reads wait one cycle for registered data
    assign avs_waitrequest = avs_read && !rd_ack_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            rd_ack_r <= 1'h0;
        else
            rd_ack_r <= avs_read && !rd_ack_r;
    end

    // ********************************
    // software registers
    // ********************************

    logic [`TCSS_SYNC_W-1:0] sync_sel_r;
    logic [`TCSS_NCH-1:0] start_r;
    tcss_cclr_arr_t counter_clear_source_r;

    // reserved bits never stored, so they read 0
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sync_sel_r <= `TCSS_SYNC_RST;
        else if (avs_write && hit_sync && avs_byteenable[0])
            sync_sel_r <= avs_writedata[`TCSS_SYNC_W-1:0] &
                `TCSS_SYNC_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            start_r <= `TCSS_START_RST;
        else if (avs_write && hit_start && avs_byteenable[0])
            start_r <= avs_writedata[`TCSS_NCH-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            counter_clear_source_r <= '0;
        else if (avs_write && ctl_dec[`TCSS_IDX_W] && avs_byteenable[0])
            counter_clear_source_r[ctl_dec[`TCSS_IDX_W-1:0]] <=
                avs_writedata[`TCSS_CCLR_W-1:0];
    end

    // ********************************
    // synchronisation fan-out
    // ********************************

    logic [`TCSS_NCH-1:0] sync_on;
    logic [`TCSS_NCH-1:0] own_clr;
    logic [`TCSS_NCH-1:0] sync_clr_src;
    logic any_sync_clr;
    tcss_cnt_t preset_val;
    tcss_cnt_arr_t count_w;
    tcss_chan_ctl_s [`TCSS_NCH-1:0] ctl;

    // one merged value loaded into every channel that is preset
    assign preset_val = lane_merge(count_w[wr_idx], avs_writedata,
                                   avs_byteenable);
    assign any_sync_clr = |sync_clr_src;

    genvar g;
    generate
        for (g = 0; g < `TCSS_NCH; g = g + 1)
        begin : g_ch
            assign sync_on[g] = sync_sel_r[sync_bit_of(g)];
            assign own_clr[g] = clear_event[g] &&
                counter_clear_source_r[g] == `TCSS_CCLR_OWN;
            // only a synchronised channel's clear spreads
            assign sync_clr_src[g] = own_clr[g] && sync_on[g];

            always_comb
            begin
                ctl[g].run = start_r[g];
                // own write, or a write to another synchronised channel
                ctl[g].preset = wr_cnt && (wr_idx == 3'(g) ||
                    (sync_on[wr_idx] && sync_on[g]));
                ctl[g].clear = own_clr[g] || (sync_on[g] &&
                    counter_clear_source_r[g] == `TCSS_CCLR_SYNC &&
                    any_sync_clr);
                ctl[g].preset_val = preset_val;
            end

            tcss_chan u_chan
            (
                .clk(clk),
                .rst_n(rst_n),
                .ctl(ctl[g]),
                .count(count_w[g])
            );
        end
    endgenerate

    // ********************************
    // read path
    // ********************************

    logic [`TCSS_DATA_W-1:0] rd_nxt;
    logic [`TCSS_DATA_W-1:0] readdata_r;

    // unmapped addresses read zero
    always_comb
    begin
        rd_nxt = '0;
        if (hit_sync)
            rd_nxt[`TCSS_SYNC_W-1:0] = sync_sel_r;
        else if (hit_start)
            rd_nxt[`TCSS_NCH-1:0] = start_r;
        else if (cnt_dec[`TCSS_IDX_W])
            rd_nxt[`TCSS_CNT_W-1:0] = count_w[wr_idx];
        else if (ctl_dec[`TCSS_IDX_W])
            rd_nxt[`TCSS_CCLR_W-1:0] =
                counter_clear_source_r[ctl_dec[`TCSS_IDX_W-1:0]];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            readdata_r <= '0;
        else if (avs_read && !rd_ack_r)
            readdata_r <= rd_nxt;
    end

    assign avs_readdata = readdata_r;
    assign channel_up_counter = count_w;
    assign channel_sync_select = sync_sel_r;

endmodule

/* File: tb/tcss_chk.sv */
// checker of the sync select register, presets and bus timing
`timescale 1ns/1ps
`include "tcss_params.svh"
module tcss_chk
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`TCSS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`TCSS_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [`TCSS_DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [`TCSS_NCH-1:0] clear_event,
    input wire tcss_pkg::tcss_cnt_arr_t channel_up_counter,
    input wire logic [`TCSS_SYNC_W-1:0] channel_sync_select
);
    import tcss_pkg::*;
    // ****
    // properties
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] v;
    logic [5:0] wi;
    logic sw;
    assign v = {channel_sync_select[7:6], channel_sync_select[2:0]};
    assign wi = avs_address[7:2];
    assign sw = avs_write && wi == 6'h00 && avs_byteenable[0];
    function automatic logic all_eq(tcss_cnt_arr_t c, logic [4:0] m,
        tcss_cnt_t x);
        all_eq = 1'h1;
        for (int i = 0; i < 5; i++)
            if (m[i] && c[i] != x)
                all_eq = 1'h0;
    endfunction
    sequence s_rd_ans;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    a_read_wait: assert property ($rose(avs_read) |-> s_rd_ans)
        else $error("read answer not after one cycle");
    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write stalled");
    a_read_sel: assert property (avs_read && !avs_waitrequest &&
        wi == 6'h00 |->
        avs_readdata == {24'h000000, $past(channel_sync_select)})
        else $error("select read back wrong");
    a_rsvd_zero: assert property (channel_sync_select[5:3] == 3'h0)
        else $error("reserved select bits set");
    a_sel_write: assert property (sw |=> channel_sync_select ==
        ($past(avs_writedata[7:0]) & `TCSS_SYNC_MASK))
        else $error("select write not stored");
    a_sel_hold: assert property (!sw |=> $stable(channel_sync_select))
        else $error("select changed without write");
    a_reset_val: assert property ($rose(rst_n) |->
        channel_sync_select == `TCSS_SYNC_RST && channel_up_counter == '0)
        else $error("reset values wrong");
    a_sync_preset: assert property (avs_write &&
        wi inside {[4:8]} && avs_byteenable[1:0] == 2'h3 &&
        v[3'(wi - 6'h04)] |=>
        all_eq(channel_up_counter, $past(v), $past(avs_writedata[15:0])))
        else $error("synchronised preset missed a channel");
endmodule

bind tcss_top tcss_chk u_chk
(
    .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .clear_event,
    .channel_up_counter, .channel_sync_select
);

/* File: tb/timer_channel_sync_select_test.sv */
// random bench with a reference model of select, clear and preset
`timescale 1ns/1ps
`include "tcss_params.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end
module timer_channel_sync_select_test;
    import tcss_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [4:0] clear_event = 5'h00;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] channel_sync_select;
    tcss_cnt_arr_t channel_up_counter;
    tcss_cnt_arr_t ecnt;
    int error_cnt = 0;
    int checks = 0;
    int msel, mst, erd, mcnt[5], mclr[5];
    tcss_top u_dut
    (
        .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .clear_event,
        .channel_up_counter, .channel_sync_select
    );
    initial forever #20 clk = ~clk;
    // ****
    // reference model
    // ****
    always @(posedge clk)
    begin
        int nc[5], v, k, g;
        v = {msel[7:6], msel[2:0]};
        k = avs_address[7:2];
        g = 0;
        nc = mcnt;
        if (avs_read && avs_waitrequest)
            erd = k == 0 ? msel : k == 1 ? mst : k inside {[4:8]} ?
                mcnt[k-4] : k inside {[12:16]} ? mclr[k-12] : 0;
        for (int i = 0; i < 5; i++)
            if (mclr[i] == 1 && clear_event[i] && v[i]) g = 1;
        for (int i = 0; i < 5; i++)
        begin
            if (mst[i]) nc[i] = (mcnt[i] + 1) & 16'hFFFF;
            if (mclr[i] == 1 && clear_event[i] || g && v[i] && mclr[i] == 3)
                nc[i] = 0;
        end
        if (avs_write && k inside {[4:8]})
            for (int i = 0; i < 5; i++)
                if (i == k - 4 || v[k-4] && v[i])
                    nc[i] = avs_writedata[15:0];
        if (avs_write && avs_byteenable[0])
        begin
            if (k == 0) msel = avs_writedata[7:0] & `TCSS_SYNC_MASK;
            if (k == 1) mst = avs_writedata[4:0];
            if (k inside {[12:16]}) mclr[k-12] = avs_writedata[2:0];
        end
        mcnt = nc;
        if (!rst_n)
        begin
            msel = 0;
            mst = 0;
            mcnt = '{0, 0, 0, 0, 0};
            mclr = '{0, 0, 0, 0, 0};
        end
    end
    always @(negedge clk)
    begin
        for (int i = 0; i < 5; i++)
            ecnt[i] = 16'(mcnt[i]);
        `CHK("select", 8'(msel), channel_sync_select)
        `CHK("counters", ecnt, channel_up_counter)
    end
    // ****
    // bus cycles and stimulus
    // ****
    task automatic finish_test();
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= b;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            finish_test();
        end
        if (!w) `CHK("readdata", 32'(erd), avs_readdata)
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    initial
    begin
        logic [7:0] a;
        logic [31:0] d;
        logic [3:0] b;
        void'($urandom(73135));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int n = 0; n < 700; n++)
        begin
            @(posedge clk);
            rst_n <= !(n inside {[350:352]});
            clear_event <= $urandom % 4 ? 5'h00 : 5'($urandom);
            a = 8'($urandom % 18) << 2;
            d = $urandom;
            // clear-source codes none, own, unused or sync
            if (a >= 8'h30)
                d[2] = 1'h0;
            // reserved bits written 0, never a lone sync bit
            if (a == 8'h00)
            begin
                d[5:3] = 3'h0;
                if ($countones({d[7:6], d[2:0]}) == 1)
                    d[7:6] = 2'h3;
            end
            b = ($urandom % 8 == 0 && a < 8'h10) ? 4'hE : 4'hF;
            if ((n < 350 || n > 354) && $urandom % 3 != 2)
                acc($urandom % 2, a, d, b);
        end
        finish_test();
    end
endmodule
